// ### hdl/data_space_address_decoder.sv
// How it works
// - 224 addresses: registers, I/O, then SRAM
// - five addressing modes are supported
// - direct address reaches whole data space
// - registers 26..31 form three pointer pairs
// - displacement 0..63 added to middle/high pair
// - pre-decrement/post-increment update pointer pair
// - every location reachable in every mode
// - io in/out moves byte between register and I/O
// - set/clear one bit in lower I/O half
// - test one bit in lower half, skip
// - peripherals live only in I/O space
`timescale 1ns/1ps
module data_space_address_decoder
  import data_space_pkg::*;
(
  input  wire logic             mclk_i,
  input  wire logic             resetn_i,
  input  wire logic             req_i,
  input  data_space_pkg::op_e   op_i,
  input  data_space_pkg::addr_mode_e mode_i,
  input  data_space_pkg::ptr_sel_e   ptr_sel_i,
  input  wire logic [15:0]      direct_addr_i,
  input  wire logic [5:0]       disp_i,
  input  wire logic [5:0]       io_addr_i,
  input  wire logic [2:0]       bit_i,
  input  wire logic [4:0]       reg_sel_i,
  input  wire logic [7:0]       wdata_i,
  input  wire logic [63:0]      io_impl_i,
  input  wire logic [7:0]       io_rdata_i,
  output logic      [7:0]       rdata_o,
  output logic                  rvalid_o,
  output logic                  skip_o,
  output logic                  miss_o,
  output logic                  io_we_o,
  output logic      [5:0]       io_addr_o,
  output logic      [7:0]       io_wdata_o
);
  import data_space_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // storage
  logic [7:0]  regs [REG_COUNT];
  logic [7:0]  sram [SRAM_COUNT];
  logic [7:0]  next_regs [REG_COUNT];
  logic [7:0]  next_sram [SRAM_COUNT];
  logic [7:0]  rdata;
  logic [7:0]  next_rdata;
  logic        rvalid;
  logic        next_rvalid;
  logic        skip;
  logic        next_skip;
  logic        miss;
  logic        next_miss;
  logic        io_we;
  logic        next_io_we;
  logic [5:0]  io_addr;
  logic [5:0]  next_io_addr;
  logic [7:0]  io_wdata;
  logic [7:0]  next_io_wdata;

  ////////////////////////////////////////////////////////////////////////////
  // pointer selection and address forming
  logic [15:0]     base;
  logic [15:0]     ind_addr;
  logic [15:0]     new_ptr;
  logic            write_back;
  logic [15:0]     eff_addr;
  target_e         target;
  logic [6:0]      index;
  logic [4:0]      ptr_lo;
  addr_mode_e      eff_mode;

  function automatic logic [4:0] ptr_reg(input ptr_sel_e sel);
    ptr_reg = PTR_LOW_REG + {sel, 1'b0};
  endfunction

  function automatic logic io_present(input logic [63:0] impl, input logic [5:0] a);
    io_present = impl[a];
  endfunction

  always_comb
  begin
    ptr_lo   = ptr_reg(ptr_sel_i);
    base     = {regs[ptr_lo + 5'h01], regs[ptr_lo]};
    eff_mode = mode_i;
    if (mode_i == MODE_DISP && ptr_sel_i == PTR_LOW)
    begin
      eff_mode = MODE_PTR;
    end
  end

  pointer_calc u_pointer_calc
  (
    .base_i       (base),
    .disp_i       (disp_i),
    .mode_i       (eff_mode),
    .addr_o       (ind_addr),
    .new_ptr_o    (new_ptr),
    .write_back_o (write_back)
  );

  assign eff_addr = (op_i == OP_LOAD || op_i == OP_STORE)
                    ? ((mode_i == MODE_DIRECT) ? direct_addr_i : ind_addr)
                    : (IO_BASE + {10'h000, io_addr_i});

  space_decode u_space_decode
  (
    .addr_i   (eff_addr),
    .target_o (target),
    .index_o  (index)
  );

  ////////////////////////////////////////////////////////////////////////////
  // pending I/O write forwarding
  logic       fwd_hit;
  logic [7:0] io_cur;

  // the peripheral takes io_we one edge late, so a back-to-back access sees the pending byte
  always_comb
  begin
    fwd_hit = io_we && (io_addr == index[5:0]);
    io_cur  = RESET_BYTE;
    if (fwd_hit)
    begin
      io_cur = io_wdata;
    end
    else if (io_present(io_impl_i, index[5:0]))
    begin
      io_cur = io_rdata_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // access next state
  logic [7:0] cur;
  logic [7:0] mod;
  logic       bit_ok;
  logic       ptr_upd;

  always_comb
  begin
    for (int i = 0; i < REG_COUNT; i++)
    begin
      next_regs[i] = regs[i];
    end
    for (int i = 0; i < SRAM_COUNT; i++)
    begin
      next_sram[i] = sram[i];
    end
    next_rdata    = rdata;
    next_rvalid   = 1'b0;
    next_skip     = 1'b0;
    next_miss     = 1'b0;
    next_io_we    = 1'b0;
    next_io_addr  = io_addr;
    next_io_wdata = io_wdata;
    cur           = RESET_BYTE;
    mod           = RESET_BYTE;
    ptr_upd       = 1'b0;
    bit_ok        = (io_addr_i < IO_BIT_LIMIT);
    // current byte at the target, I/O from io_cur: pending write, then peripheral, zero if unused
    case (target)
      TGT_REG:
      begin
        cur = regs[index[4:0]];
      end
      TGT_IO:
      begin
        cur = io_cur;
      end
      TGT_SRAM:
      begin
        cur = sram[index];
      end
      default:
      begin
        cur = RESET_BYTE;
      end
    endcase
    if (req_i)
    begin
      next_io_addr = index[5:0];
      case (op_i)
        OP_LOAD:
        begin
          next_rdata  = cur;
          next_rvalid = 1'b1;
          next_miss   = (target == TGT_NONE);
          ptr_upd     = (mode_i != MODE_DIRECT);
          next_regs[reg_sel_i] = cur;
        end
        OP_STORE:
        begin
          next_miss = (target == TGT_NONE);
          ptr_upd   = (mode_i != MODE_DIRECT);
          case (target)
            TGT_REG:
            begin
              next_regs[index[4:0]] = wdata_i;
            end
            TGT_IO:
            begin
              next_io_we    = io_present(io_impl_i, index[5:0]);
              next_io_wdata = wdata_i;
            end
            TGT_SRAM:
            begin
              next_sram[index] = wdata_i;
            end
            default:
            begin
              next_miss = 1'b1;
            end
          endcase
        end
        OP_IO_IN:
        begin
          next_rdata           = cur;
          next_rvalid          = 1'b1;
          next_regs[reg_sel_i] = cur;
        end
        OP_IO_OUT:
        begin
          next_io_we    = io_present(io_impl_i, io_addr_i);
          next_io_wdata = regs[reg_sel_i];
        end
        OP_SET_BIT, OP_CLEAR_BIT:
        begin
          mod           = cur;
          mod[bit_i]    = (op_i == OP_SET_BIT);
          next_io_we    = bit_ok && io_present(io_impl_i, io_addr_i);
          next_io_wdata = mod;
          next_miss     = !bit_ok;
        end
        OP_SKIP_SET, OP_SKIP_CLEAR:
        begin
          next_skip   = bit_ok && (cur[bit_i] == (op_i == OP_SKIP_SET));
          next_rvalid = 1'b1;
          next_rdata  = cur;
          next_miss   = !bit_ok;
        end
        default:
        begin
          next_miss = 1'b1;
        end
      endcase
      if (ptr_upd && write_back)
      begin
        next_regs[ptr_lo]         = new_ptr[7:0];
        next_regs[ptr_lo + 5'h01] = new_ptr[15:8];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      for (int i = 0; i < REG_COUNT; i++)
      begin
        regs[i] <= RESET_BYTE;
      end
      for (int i = 0; i < SRAM_COUNT; i++)
      begin
        sram[i] <= RESET_BYTE;
      end
      rdata    <= RESET_BYTE;
      rvalid   <= 1'b0;
      skip     <= 1'b0;
      miss     <= 1'b0;
      io_we    <= 1'b0;
      io_addr  <= 6'h00;
      io_wdata <= RESET_BYTE;
    end
    else
    begin
      regs     <= next_regs;
      sram     <= next_sram;
      rdata    <= next_rdata;
      rvalid   <= next_rvalid;
      skip     <= next_skip;
      miss     <= next_miss;
      io_we    <= next_io_we;
      io_addr  <= next_io_addr;
      io_wdata <= next_io_wdata;
    end
  end

  assign rdata_o    = rdata;
  assign rvalid_o   = rvalid;
  assign skip_o     = skip;
  assign miss_o     = miss;
  assign io_we_o    = io_we;
  assign io_addr_o  = io_addr;
  assign io_wdata_o = io_wdata;
endmodule

// ### hdl/data_space_pkg.sv
package data_space_pkg;
  localparam int unsigned ADDR_W        = 16;
  localparam int unsigned DATA_W        = 8;
  localparam int unsigned REG_COUNT     = 32;
  localparam int unsigned IO_COUNT      = 64;
  localparam int unsigned SRAM_COUNT    = 128;
  localparam logic [15:0] REG_BASE      = 16'h0000;
  localparam logic [15:0] IO_BASE       = 16'h0020;
  localparam logic [15:0] SRAM_BASE     = 16'h0060;
  localparam logic [15:0] SPACE_END     = 16'h00e0;
  localparam logic [5:0]  IO_BIT_LIMIT  = 6'h20;
  localparam logic [5:0]  DISP_MAX      = 6'h3f;
  localparam logic [4:0]  PTR_LOW_REG   = 5'h1a;
  localparam logic [7:0]  RESET_BYTE    = 8'h00;

  typedef enum logic [2:0]
  {
    MODE_DIRECT,
    MODE_DISP,
    MODE_PTR,
    MODE_PRE_DEC,
    MODE_POST_INC
  } addr_mode_e;

  typedef enum logic [1:0]
  {
    PTR_LOW,
    PTR_MID,
    PTR_HIGH
  } ptr_sel_e;

  typedef enum logic [2:0]
  {
    OP_LOAD,
    OP_STORE,
    OP_IO_IN,
    OP_IO_OUT,
    OP_SET_BIT,
    OP_CLEAR_BIT,
    OP_SKIP_SET,
    OP_SKIP_CLEAR
  } op_e;

  typedef enum logic [1:0]
  {
    TGT_NONE,
    TGT_REG,
    TGT_IO,
    TGT_SRAM
  } target_e;
endpackage

// ### hdl/space_decode.sv
`timescale 1ns/1ps
module space_decode
  import data_space_pkg::*;
(
  input  wire logic [15:0] addr_i,
  output data_space_pkg::target_e target_o,
  output logic      [6:0]  index_o
);
  import data_space_pkg::*;
  logic [15:0] offset;
  always_comb
  begin
    offset   = 16'h0000;
    target_o = TGT_NONE;
    if (addr_i < IO_BASE)
    begin
      target_o = TGT_REG;
      offset   = addr_i - REG_BASE;
    end
    else if (addr_i < SRAM_BASE)
    begin
      target_o = TGT_IO;
      offset   = addr_i - IO_BASE;
    end
    else if (addr_i < SPACE_END)
    begin
      target_o = TGT_SRAM;
      offset   = addr_i - SRAM_BASE;
    end
    index_o = offset[6:0];
  end
endmodule

// ### hdl/pointer_calc.sv
`timescale 1ns/1ps
module pointer_calc
  import data_space_pkg::*;
(
  input  wire logic [15:0] base_i,
  input  wire logic [5:0]  disp_i,
  input  data_space_pkg::addr_mode_e mode_i,
  output logic      [15:0] addr_o,
  output logic      [15:0] new_ptr_o,
  output logic             write_back_o
);
  import data_space_pkg::*;
  always_comb
  begin
    addr_o       = base_i;
    new_ptr_o    = base_i;
    write_back_o = 1'b0;
    case (mode_i)
      MODE_DISP:
      begin
        addr_o = base_i + {10'h000, disp_i};
      end
      MODE_PRE_DEC:
      begin
        addr_o       = base_i - 16'h0001;
        new_ptr_o    = base_i - 16'h0001;
        write_back_o = 1'b1;
      end
      MODE_POST_INC:
      begin
        new_ptr_o    = base_i + 16'h0001;
        write_back_o = 1'b1;
      end
      default:
      begin
        addr_o = base_i;
      end
    endcase
  end
endmodule

// ### dv/data_space_address_decoder_assertions.sv
`timescale 1ns/1ps
module data_space_address_decoder_assertions
  import data_space_pkg::*;
(
  input wire logic             mclk_i,
  input wire logic             resetn_i,
  input wire logic             req_i,
  input data_space_pkg::op_e   op_i,
  input data_space_pkg::addr_mode_e mode_i,
  input wire logic [15:0]      direct_addr_i,
  input wire logic [5:0]       io_addr_i,
  input wire logic [2:0]       bit_i,
  input wire logic [63:0]      io_impl_i,
  input wire logic [7:0]       io_rdata_i,
  input wire logic [7:0]       rdata_o,
  input wire logic             rvalid_o,
  input wire logic             skip_o,
  input wire logic             miss_o,
  input wire logic             io_we_o,
  input wire logic [5:0]       io_addr_o,
  input wire logic [7:0]       io_wdata_o
);
  import data_space_pkg::*;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  logic bit_op;
  logic low_ok;
  logic [7:0] io_cur;
  // byte the location holds this cycle: a pending write not yet taken by the peripheral wins
  assign io_cur = (io_we_o && io_addr_o == io_addr_i) ? io_wdata_o : io_rdata_i;
  assign bit_op = op_i inside {OP_SET_BIT, OP_CLEAR_BIT, OP_SKIP_SET, OP_SKIP_CLEAR};
  assign low_ok = (io_addr_i < IO_BIT_LIMIT) && io_impl_i[io_addr_i];
  ////////////////////////////////////////////////////////////////////////////////
  AST_IDLE_QUIET: assert property (!req_i |=> !rvalid_o && !io_we_o && !skip_o && !miss_o)
    else $error("pulse without request");
  AST_IDLE_HOLD: assert property (!req_i |=> $stable(rdata_o) && $stable(io_addr_o))
    else $error("held output changed");
  AST_IO_OUT_WE: assert property (req_i && op_i == OP_IO_OUT && io_impl_i[io_addr_i]
    |=> io_we_o && io_addr_o == $past(io_addr_i))
    else $error("io out write missing");
  AST_BIT_HIGH_MISS: assert property (req_i && bit_op && io_addr_i >= IO_BIT_LIMIT
    |=> miss_o && !io_we_o && !skip_o)
    else $error("bit op above lower half not refused");
  AST_SET_BIT: assert property (req_i && op_i == OP_SET_BIT && low_ok
    |=> io_we_o && io_wdata_o == ($past(io_cur) | (8'h01 << $past(bit_i))))
    else $error("set bit value wrong");
  AST_CLEAR_BIT: assert property (req_i && op_i == OP_CLEAR_BIT && low_ok
    |=> io_we_o && io_wdata_o == ($past(io_cur) & ~(8'h01 << $past(bit_i))))
    else $error("clear bit value wrong");
  AST_SKIP: assert property (req_i && op_i inside {OP_SKIP_SET, OP_SKIP_CLEAR} && low_ok
    |=> skip_o == ($past(io_cur[bit_i]) ~^ ($past(op_i) == OP_SKIP_SET)))
    else $error("skip result wrong");
  AST_UNIMPL_IN: assert property (req_i && op_i == OP_IO_IN && !io_impl_i[io_addr_i]
    |=> rvalid_o && rdata_o == 8'h00 && !io_we_o)
    else $error("unused io read not zero");
  AST_DIRECT_MISS: assert property (req_i && op_i inside {OP_LOAD, OP_STORE} && mode_i == MODE_DIRECT
    && direct_addr_i >= SPACE_END |=> miss_o && !io_we_o)
    else $error("address above space not refused");
  COV_SET: cover property (req_i && op_i == OP_SET_BIT ##1 io_we_o);
  COV_SKIP: cover property (skip_o);
  COV_MISS: cover property (miss_o);
endmodule

bind data_space_address_decoder data_space_address_decoder_assertions chk
(
  .mclk_i, .resetn_i, .req_i, .op_i, .mode_i, .direct_addr_i, .io_addr_i, .bit_i, .io_impl_i,
  .io_rdata_i, .rdata_o, .rvalid_o, .skip_o, .miss_o, .io_we_o, .io_addr_o, .io_wdata_o
);

// ### dv/io_space_model.sv
`timescale 1ns/1ps
module io_space_model
(
  input  wire logic        mclk_i,
  input  wire logic [5:0]  idx_i,
  input  wire logic [63:0] impl_i,
  input  wire logic        we_i,
  input  wire logic [5:0]  waddr_i,
  input  wire logic [7:0]  wdata_i,
  output logic      [7:0]  rdata_o
);
  logic [7:0] mem [64];
  initial foreach (mem[i]) mem[i] = 8'h00;
  // unused places float, shown as all ones
  assign rdata_o = impl_i[idx_i] ? mem[idx_i] : 8'hff;
  always @(posedge mclk_i) if (we_i && impl_i[waddr_i]) mem[waddr_i] <= wdata_i;
endmodule

// ### dv/data_space_address_decoder_test.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin bad_count++; \
  $display("BAD %s exp %h got %h", n, e, s); end end
module data_space_address_decoder_test;
  import data_space_pkg::*;
  logic mclk_i = 0, resetn_i = 0, req = 0;
  op_e op = OP_LOAD;
  addr_mode_e mode = MODE_DIRECT;
  ptr_sel_e ptr = PTR_LOW;
  logic [15:0] daddr = 16'h0000;
  logic [5:0] disp = 6'h00, ioa = 6'h00, io_addr;
  logic [2:0] bitn = 3'h0;
  logic [4:0] rsel = 5'h02;
  logic [7:0] wd = 8'h00, io_rd, rdata, io_wd;
  logic [63:0] impl = 64'h0000_0001_0100_0000;
  logic rvalid, skip, miss, io_we;
  int bad_count = 0, checks = 0;
  typedef struct { logic [15:0] a; logic [7:0] d; logic m; } row_s;
  row_s rows [7] = '{'{16'h0000, 8'h11, 0}, '{16'h001f, 8'h22, 0}, '{16'h0038, 8'h99, 0},
                     '{16'h0060, 8'h33, 0}, '{16'h00df, 8'h44, 0}, '{16'h00e0, 8'h55, 1}, '{16'hffff, 8'h66, 1}};
  initial forever #20 mclk_i = ~mclk_i;
  data_space_address_decoder dut (.mclk_i(mclk_i), .resetn_i(resetn_i), .req_i(req), .op_i(op),
    .mode_i(mode), .ptr_sel_i(ptr), .direct_addr_i(daddr), .disp_i(disp), .io_addr_i(ioa),
    .bit_i(bitn), .reg_sel_i(rsel), .wdata_i(wd), .io_impl_i(impl), .io_rdata_i(io_rd),
    .rdata_o(rdata), .rvalid_o(rvalid), .skip_o(skip), .miss_o(miss), .io_we_o(io_we),
    .io_addr_o(io_addr), .io_wdata_o(io_wd));
  io_space_model peri (.mclk_i(mclk_i), .idx_i(ioa), .impl_i(impl), .we_i(io_we),
    .waddr_i(io_addr), .wdata_i(io_wd), .rdata_o(io_rd));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic acc(input op_e o, input addr_mode_e m, input logic [15:0] a,
                     input logic [5:0] io, input logic [2:0] b, input logic [7:0] d);
    op = o;
    mode = m;
    daddr = a;
    ioa = io;
    bitn = b;
    wd = d;
    req = 1;
    @(negedge mclk_i);
  endtask
  task automatic conclude;
    if (bad_count == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    #100000;
    bad_count++;
    conclude;
  end
  initial
  begin
    repeat (3) @(negedge mclk_i);
    `CHK("rvalid", 1'b0, rvalid)
    `CHK("io_we", 1'b0, io_we)
    resetn_i = 1;
    foreach (rows[i])
    begin
      acc(OP_STORE, MODE_DIRECT, rows[i].a, rows[i].a[5:0] - 6'h20, 3'h0, rows[i].d);
      acc(OP_LOAD, MODE_DIRECT, rows[i].a, rows[i].a[5:0] - 6'h20, 3'h0, 8'h00);
      `CHK("rvalid", 1'b1, rvalid)
      `CHK("rdata", rows[i].m ? 8'h00 : rows[i].d, rdata)
      `CHK("miss", rows[i].m, miss)
    end
    acc(OP_STORE, MODE_DIRECT, 16'h001a, 6'h00, 3'h0, 8'h60);
    acc(OP_STORE, MODE_DIRECT, 16'h001b, 6'h00, 3'h0, 8'h00);
    acc(OP_STORE, MODE_POST_INC, 16'h0000, 6'h00, 3'h0, 8'h5a);
    acc(OP_LOAD, MODE_DIRECT, 16'h001a, 6'h00, 3'h0, 8'h00);
    `CHK("post inc ptr", 8'h61, rdata)
    acc(OP_LOAD, MODE_PRE_DEC, 16'h0000, 6'h00, 3'h0, 8'h00);
    `CHK("pre dec data", 8'h5a, rdata)
    acc(OP_LOAD, MODE_DIRECT, 16'h001a, 6'h00, 3'h0, 8'h00);
    `CHK("pre dec ptr", 8'h60, rdata)
    acc(OP_STORE, MODE_DIRECT, 16'h001c, 6'h00, 3'h0, 8'h60);
    acc(OP_STORE, MODE_DIRECT, 16'h001d, 6'h00, 3'h0, 8'h00);
    ptr = PTR_MID;
    disp = 6'h3f;
    acc(OP_STORE, MODE_DISP, 16'h0000, 6'h00, 3'h0, 8'h77);
    acc(OP_LOAD, MODE_DIRECT, 16'h009f, 6'h00, 3'h0, 8'h00);
    `CHK("disp data", 8'h77, rdata)
    acc(OP_LOAD, MODE_PTR, 16'h0000, 6'h00, 3'h0, 8'h00);
    `CHK("ptr data", 8'h5a, rdata)
    acc(OP_STORE, MODE_DIRECT, 16'h0005, 6'h00, 3'h0, 8'hc3);
    rsel = 5'h05;
    acc(OP_IO_OUT, MODE_DIRECT, 16'h0000, 6'h18, 3'h0, 8'h00);
    `CHK("io_we", 1'b1, io_we)
    `CHK("io_wdata", 8'hc3, io_wd)
    `CHK("io_addr", 6'h18, io_addr)
    acc(OP_SET_BIT, MODE_DIRECT, 16'h0000, 6'h18, 3'h2, 8'h00);
    acc(OP_CLEAR_BIT, MODE_DIRECT, 16'h0000, 6'h18, 3'h0, 8'h00);
    `CHK("clear bit", 8'hc6, io_wd)
    acc(OP_SKIP_SET, MODE_DIRECT, 16'h0000, 6'h18, 3'h1, 8'h00);
    `CHK("skip set", 1'b1, skip)
    acc(OP_SKIP_CLEAR, MODE_DIRECT, 16'h0000, 6'h18, 3'h1, 8'h00);
    `CHK("skip clear", 1'b0, skip)
    acc(OP_SET_BIT, MODE_DIRECT, 16'h0000, 6'h20, 3'h0, 8'h00);
    `CHK("bit high miss", 1'b1, miss)
    acc(OP_IO_IN, MODE_DIRECT, 16'h0000, 6'h05, 3'h0, 8'h00);
    `CHK("unused io", 8'h00, rdata)
    acc(OP_IO_IN, MODE_DIRECT, 16'h0000, 6'h18, 3'h0, 8'h00);
    `CHK("io in", 8'hc6, rdata)
    req = 0;
    @(negedge mclk_i);
    `CHK("idle rvalid", 1'b0, rvalid)
    conclude;
  end
endmodule
